// ### hw/amh_anomaly_manager.v
// Purpose: anomaly classes, admission, actions, lamps, horn control
// Assumes: inputs synchronous; causes are levels, four classes of N anomalies each
// Notes: OFF/RESET cancel is outside; restart inhibit relies on acknowledge
// Contract
// - Warnings only signal; never stop engine or open breaker.
// - Unload in parallel ramps power down, then acts as deactivation.
// - Deactivation opens breaker at once, stops engine with cooling.
// - Alarm opens breaker at once, stops engine without cooling.
// - Restart inhibited while unload, deactivation or alarm unacknowledged.
// - Without bypass, alarm admitted only when no other alarm active.
// - Without bypass, deactivation admitted only with no alarm or deactivation.
// - Without bypass, unload admitted only with no alarm, deactivation, unload.
// - Without bypass, warning admitted only with no alarm, deactivation, unload.
// - Bypass bit set admits any anomaly regardless of others.
// - New anomaly sounds internal horn; external horn follows identically.
// - Flash warning or alarm lamp and code until acknowledged.
// - Non-warning anomalies disconnect generator and stop engine.
// - Anomaly stays displayed until acknowledged even if cause gone.
// - Acknowledged warning clears itself when its cause goes away.
// - Start key silences horn without acknowledging.
// - Acknowledge input silences horn only on rising edge.
// - Password bypass input drops password need for serial commands.
// - Horn duration 0 never, 999 until silenced, else also times out.
// - Silenced anomaly stays unacknowledged and flashing.
// - Acknowledge input edge or serial 52 acknowledges and cancels horn.
`timescale 1ns/1ps
`include "amh_regs.vh"
module amh_anomaly_manager #(
    parameter N = 8,
    parameter SEC_CYCLES = `AMH_CLK_HZ,
    parameter WINDOW_CYCLES = `AMH_CMD_WINDOW_S * `AMH_CLK_HZ,
    parameter FLASH_CYCLES = `AMH_CLK_HZ / 2
) (
    clk,
    nrst,
    causeWarn,
    causeUnload,
    causeDeact,
    causeAlarm,
    resetAnomalies,
    parallelMode,
    powerLow,
    optionBits,
    hornDuration,
    password,
    startKey,
    ackInputFunction,
    passwordBypassInput,
    wrEn,
    wrAddr,
    wrData,
    internalHorn,
    externalHornOutput,
    warnLamp,
    alarmLamp,
    codeVisible,
    activeClasses,
    rampDown,
    generatorBreakerOpen,
    engineStopCool,
    engineStopNow,
    restartInhibit
);
    input wire clk;
    input wire nrst;
    input wire [N-1:0] causeWarn;
    input wire [N-1:0] causeUnload;
    input wire [N-1:0] causeDeact;
    input wire [N-1:0] causeAlarm;
    input wire resetAnomalies;
    input wire parallelMode;
    input wire powerLow;
    input wire [15:0] optionBits;
    input wire [9:0] hornDuration;
    input wire [15:0] password;
    input wire startKey;
    input wire ackInputFunction;
    input wire passwordBypassInput;
    input wire wrEn;
    input wire [15:0] wrAddr;
    input wire [15:0] wrData;
    output reg internalHorn;
    output reg externalHornOutput;
    output reg warnLamp;
    output reg alarmLamp;
    output reg codeVisible;
    output reg [3:0] activeClasses;
    output reg rampDown;
    output reg generatorBreakerOpen;
    output reg engineStopCool;
    output reg engineStopNow;
    output reg restartInhibit;

    reg [N-1:0] warn_reg, unload_reg, deact_reg, alarm_reg;
    reg [N-1:0] warnUnack_reg, unloadUnack_reg, deactUnack_reg, alarmUnack_reg;
    reg [N-1:0] warn_next, unload_next, deact_next, alarm_next;
    reg ackInPrev_reg;
    reg horn_reg;
    reg [9:0] hornSecs_reg;
    reg [31:0] flash_reg;
    reg flashPhase_reg;
    wire cmdSilence;
    wire cmdAck;
    wire secTick;

    wire ackEdge = ackInputFunction && !ackInPrev_reg;
    wire ackAll = ackEdge || cmdAck;
    wire bypass = optionBits[`AMH_OPT_BYPASS];
    wire anyW = |warn_reg;
    wire anyU = |unload_reg;
    wire anyD = |deact_reg;
    wire anyA = |alarm_reg;
    wire [N-1:0] newA = causeAlarm & ~alarm_reg;
    wire [N-1:0] newD = causeDeact & ~deact_reg;
    wire [N-1:0] newU = causeUnload & ~unload_reg;
    wire [N-1:0] newW = causeWarn & ~warn_reg;
    // Admission gates; simultaneous newcomers of one class go in together
    wire okA = bypass || !anyA;
    wire okD = bypass || (!anyA && !anyD);
    wire okU = bypass || (!anyA && !anyD && !anyU);
    wire okW = bypass || (!anyA && !anyD && !anyU);
    wire [N-1:0] admA = okA ? newA : {N{1'b0}};
    wire [N-1:0] admD = okD ? newD : {N{1'b0}};
    wire [N-1:0] admU = okU ? newU : {N{1'b0}};
    wire [N-1:0] admW = okW ? newW : {N{1'b0}};
    wire newAnomaly = |{admA, admD, admU, admW};
    wire hornEnabled = hornDuration != `AMH_HORN_OFF;
    wire hornTimed = hornDuration != `AMH_HORN_FOREVER;
    wire silence = startKey || ackEdge || cmdSilence || cmdAck;

    amh_serial_cmd #(.WINDOW_CYCLES(WINDOW_CYCLES)) uCmd (
        .clk(clk),
        .nrst(nrst),
        .wrEn(wrEn),
        .wrAddr(wrAddr),
        .wrData(wrData),
        .password(password),
        .passwordBypass(passwordBypassInput),
        .cmdSilence(cmdSilence),
        .cmdAck(cmdAck)
    );

    amh_tick #(.CYCLES(SEC_CYCLES)) uTick (
        .clk(clk),
        .nrst(nrst),
        .restart(newAnomaly),
        .tick(secTick)
    );

    // Latched anomalies; reset clears only those whose cause is gone
    always @* begin
        warn_next = warn_reg | admW;
        unload_next = unload_reg | admU;
        deact_next = deact_reg | admD;
        alarm_next = alarm_reg | admA;
        // Acknowledged warnings fall once their cause goes
        warn_next = warn_next & ~(~warnUnack_reg & ~causeWarn & warn_reg);
        if (resetAnomalies) begin
            unload_next = unload_next & ~(~unloadUnack_reg & ~causeUnload & unload_reg);
            deact_next = deact_next & ~(~deactUnack_reg & ~causeDeact & deact_reg);
            alarm_next = alarm_next & ~(~alarmUnack_reg & ~causeAlarm & alarm_reg);
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            warn_reg <= {N{1'b0}};
            unload_reg <= {N{1'b0}};
            deact_reg <= {N{1'b0}};
            alarm_reg <= {N{1'b0}};
            warnUnack_reg <= {N{1'b0}};
            unloadUnack_reg <= {N{1'b0}};
            deactUnack_reg <= {N{1'b0}};
            alarmUnack_reg <= {N{1'b0}};
            ackInPrev_reg <= 1'b0;
        end else begin
            warn_reg <= warn_next;
            unload_reg <= unload_next;
            deact_reg <= deact_next;
            alarm_reg <= alarm_next;
            ackInPrev_reg <= ackInputFunction;
            // Set wins: a newcomer in the ack cycle stays unacknowledged
            warnUnack_reg <= (ackAll ? {N{1'b0}} : warnUnack_reg) | admW;
            unloadUnack_reg <= (ackAll ? {N{1'b0}} : unloadUnack_reg) | admU;
            deactUnack_reg <= (ackAll ? {N{1'b0}} : deactUnack_reg) | admD;
            alarmUnack_reg <= (ackAll ? {N{1'b0}} : alarmUnack_reg) | admA;
        end
    end

    // Horn: raised by a new anomaly, silencing never touches acknowledge
    always @(posedge clk) begin
        if (!nrst) begin
            horn_reg <= 1'b0;
            hornSecs_reg <= 10'h000;
        end else if (newAnomaly && hornEnabled) begin
            horn_reg <= 1'b1;
            hornSecs_reg <= 10'h000;
        end else if (silence) begin
            horn_reg <= 1'b0;
        end else if (horn_reg && hornTimed && secTick) begin
            hornSecs_reg <= hornSecs_reg + 10'h001;
            if (hornSecs_reg + 10'h001 >= hornDuration)
                horn_reg <= 1'b0;
        end else if (!hornEnabled) begin
            horn_reg <= 1'b0;
        end
    end

    // Flash phase free-runs; lamps need no exact phase
    always @(posedge clk) begin
        if (!nrst) begin
            flash_reg <= 32'h0;
            flashPhase_reg <= 1'b0;
        end else if (flash_reg >= FLASH_CYCLES - 1) begin
            flash_reg <= 32'h0;
            flashPhase_reg <= !flashPhase_reg;
        end else begin
            flash_reg <= flash_reg + 32'h1;
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            internalHorn <= 1'b0;
            externalHornOutput <= 1'b0;
            warnLamp <= 1'b0;
            alarmLamp <= 1'b0;
            codeVisible <= 1'b0;
            activeClasses <= 4'h0;
            rampDown <= 1'b0;
            generatorBreakerOpen <= 1'b0;
            engineStopCool <= 1'b0;
            engineStopNow <= 1'b0;
            restartInhibit <= 1'b0;
        end else begin
            internalHorn <= horn_reg;
            externalHornOutput <= horn_reg;
            warnLamp <= (|warnUnack_reg) ? flashPhase_reg : anyW;
            alarmLamp <= (|{unloadUnack_reg, deactUnack_reg, alarmUnack_reg}) ?
                flashPhase_reg : (anyU || anyD || anyA);
            // Code blinks while unacknowledged, steady once acknowledged
            codeVisible <= (|{warnUnack_reg, unloadUnack_reg, deactUnack_reg,
                alarmUnack_reg}) ? flashPhase_reg : (anyW || anyU || anyD || anyA);
            activeClasses[`AMH_CLASS_WARN] <= anyW;
            activeClasses[`AMH_CLASS_UNLOAD] <= anyU;
            activeClasses[`AMH_CLASS_DEACT] <= anyD;
            activeClasses[`AMH_CLASS_ALARM] <= anyA;
            // Warnings appear in none of the action terms below
            rampDown <= anyU && parallelMode && !powerLow && !anyD && !anyA;
            generatorBreakerOpen <= anyA || anyD ||
                (anyU && (!parallelMode || powerLow));
            engineStopNow <= anyA;
            engineStopCool <= !anyA && (anyD ||
                (anyU && (!parallelMode || powerLow)));
            restartInhibit <= |{unloadUnack_reg, deactUnack_reg, alarmUnack_reg};
        end
    end
endmodule

// ### hw/amh_serial_cmd.v
// Purpose: password-gated serial command decoder
// Assumes: one register write per cycle, password then code
// Notes: code pulses are one cycle wide
`timescale 1ns/1ps
`include "amh_regs.vh"
module amh_serial_cmd #(
    parameter WINDOW_CYCLES = `AMH_CMD_WINDOW_S * `AMH_CLK_HZ
) (
    clk,
    nrst,
    wrEn,
    wrAddr,
    wrData,
    password,
    passwordBypass,
    cmdSilence,
    cmdAck
);
    input wire clk;
    input wire nrst;
    input wire wrEn;
    input wire [15:0] wrAddr;
    input wire [15:0] wrData;
    input wire [15:0] password;
    input wire passwordBypass;
    output reg cmdSilence;
    output reg cmdAck;
    reg armed_reg;
    reg [31:0] timer_reg;
    wire codeWrite = wrEn && wrAddr == `AMH_ADDR_COMMAND;
    wire allowed = passwordBypass || armed_reg;
    always @(posedge clk) begin
        if (!nrst) begin
            armed_reg <= 1'b0;
            timer_reg <= 32'h0;
            cmdSilence <= 1'b0;
            cmdAck <= 1'b0;
        end else begin
            cmdSilence <= codeWrite && allowed && wrData == `AMH_CMD_SILENCE;
            cmdAck <= codeWrite && allowed && wrData == `AMH_CMD_ACK;
            if (wrEn && wrAddr == `AMH_ADDR_PASSWORD) begin
                armed_reg <= wrData == password;
                timer_reg <= 32'h0;
            end else if (codeWrite) begin
                // One code per password entry
                armed_reg <= 1'b0;
            end else if (armed_reg) begin
                if (timer_reg >= WINDOW_CYCLES - 1)
                    armed_reg <= 1'b0;
                timer_reg <= timer_reg + 32'h1;
            end
        end
    end
endmodule

// ### hw/amh_tick.v
// Purpose: one-second tick divider with restart
// Assumes: restart aligns the tick phase
// Notes: tick is a one-cycle pulse
`timescale 1ns/1ps
`include "amh_regs.vh"
module amh_tick #(
    parameter CYCLES = `AMH_CLK_HZ
) (
    clk,
    nrst,
    restart,
    tick
);
    input wire clk;
    input wire nrst;
    input wire restart;
    output reg tick;
    reg [31:0] count_reg;
    always @(posedge clk) begin
        if (!nrst || restart) begin
            count_reg <= 32'h0;
            tick <= 1'b0;
        end else if (count_reg == CYCLES - 1) begin
            count_reg <= 32'h0;
            tick <= 1'b1;
        end else begin
            count_reg <= count_reg + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule

// ### include/amh_regs.vh
// Purpose: constants for the anomaly manager and horn control block
// Assumes: 100 MHz system clock, 16-bit serial register writes
// Notes: offsets are serial holding register numbers
`ifndef AMH_REGS_VH
`define AMH_REGS_VH
`define AMH_ADDR_PASSWORD 16'h0065
`define AMH_ADDR_COMMAND 16'h0066
`define AMH_CMD_SILENCE 16'h0033
`define AMH_CMD_ACK 16'h0034
`define AMH_HORN_OFF 10'h000
`define AMH_HORN_FOREVER 10'h3E7
`define AMH_OPT_BYPASS 0
`define AMH_CLK_HZ 100000000
`define AMH_CMD_WINDOW_S 5
`define AMH_CLASS_WARN 0
`define AMH_CLASS_UNLOAD 1
`define AMH_CLASS_DEACT 2
`define AMH_CLASS_ALARM 3
`endif

// ### tb/amh_chk.sv
// Purpose: port assertions for the anomaly manager
// Assumes: one clock, synchronous active-low reset
// Notes: class bits 0..3 are warning, unload, deactivation, alarm
`timescale 1ns/1ps
module amh_chk (
    input wire clk,
    input wire nrst,
    input wire parallelMode,
    input wire powerLow,
    input wire [9:0] hornDuration,
    input wire startKey,
    input wire ackInputFunction,
    input wire internalHorn,
    input wire externalHornOutput,
    input wire [3:0] activeClasses,
    input wire rampDown,
    input wire generatorBreakerOpen,
    input wire engineStopCool,
    input wire engineStopNow,
    input wire restartInhibit
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Several cycles of warnings only, so stop outputs have settled
    a_warn_no_stop: assert property ((activeClasses == 4'h1) [*4] |->
        !(engineStopNow || engineStopCool || generatorBreakerOpen)) else $error("warn stops");
    a_alarm_stop: assert property ($rose(activeClasses[3]) |->
        ##[0:1] (engineStopNow && generatorBreakerOpen)) else $error("alarm no stop");
    a_deact_cool: assert property ($rose(activeClasses[2]) && !activeClasses[3] |->
        ##[0:1] (engineStopCool && generatorBreakerOpen)) else $error("deact no stop");
    a_unload_ramp: assert property ($rose(activeClasses[1]) && parallelMode && !powerLow &&
        activeClasses[3:2] == 2'h0 |-> ##[0:1] rampDown) else $error("unload no ramp");
    a_horn_pair: assert property (externalHornOutput == internalHorn)
        else $error("horn outputs differ");
    a_inhibit_set: assert property ($rose(|activeClasses[3:1]) |->
        ##[0:1] restartInhibit) else $error("restart not inhibited");
    a_start_quiet: assert property (startKey |-> ##[1:3] !internalHorn)
        else $error("start key no silence");
    a_ack_quiet: assert property ($rose(ackInputFunction) |-> ##[1:3] !internalHorn)
        else $error("ack edge no silence");
    a_zero_horn: assert property ((hornDuration == 10'h000) [*4] |-> !internalHorn)
        else $error("horn with zero duration");
endmodule
bind amh_anomaly_manager amh_chk u_chk (.clk(clk), .nrst(nrst), .parallelMode(parallelMode),
    .powerLow(powerLow),
    .hornDuration(hornDuration), .startKey(startKey), .ackInputFunction(ackInputFunction),
    .internalHorn(internalHorn), .externalHornOutput(externalHornOutput),
    .activeClasses(activeClasses), .rampDown(rampDown),
    .generatorBreakerOpen(generatorBreakerOpen), .engineStopCool(engineStopCool),
    .engineStopNow(engineStopNow), .restartInhibit(restartInhibit));

// ### tb/amh_panel_model.sv
// Purpose: operator panel, digital inputs and serial master
// Assumes: drives just after rising edges
// Notes: released serial lines show inverted data, never a stale copy
`timescale 1ns/1ps
module amh_panel_model (
    input wire clk,
    output reg startKey,
    output reg ackInputFunction,
    output reg passwordBypassInput,
    output reg wrEn,
    output reg [15:0] wrAddr,
    output reg [15:0] wrData
);
    initial {startKey, ackInputFunction, passwordBypassInput, wrEn, wrAddr, wrData} = 36'h0;
    task press_start;
        @(posedge clk) startKey <= 1'b1;
        @(posedge clk) startKey <= 1'b0;
    endtask
    task ack_level(input v);
        @(posedge clk) ackInputFunction <= v;
    endtask
    task ack_pulse;
        ack_level(1'b1);
        ack_level(1'b0);
    endtask
    task bypass(input v);
        @(posedge clk) passwordBypassInput <= v;
    endtask
    // One write per call; password first, code within the window
    task ser(input [15:0] a, input [15:0] d);
        @(posedge clk) {wrEn, wrAddr, wrData} <= {1'b1, a, d};
        @(posedge clk) {wrEn, wrAddr, wrData} <= {1'b0, ~a, ~d};
    endtask
endmodule

// ### tb/tb_top.sv
// Purpose: self-checking bench for the anomaly manager
// Assumes: short tick, window and flash counts
// Notes: checks sample 1 ns after an edge
`timescale 1ns/1ps
module tb_top;
    localparam [15:0] PW = 16'h1234;
    reg clk = 1'b0;
    reg nrst = 1'b0;
    reg [7:0] causeWarn, causeUnload, causeDeact, causeAlarm;
    reg resetAnomalies, parallelMode, powerLow;
    reg [15:0] optionBits;
    reg [9:0] hornDuration;
    wire startKey, ackInputFunction, passwordBypassInput, wrEn;
    wire [15:0] wrAddr, wrData;
    wire internalHorn, externalHornOutput, warnLamp, alarmLamp, codeVisible;
    wire [3:0] activeClasses;
    wire rampDown, generatorBreakerOpen, engineStopCool, engineStopNow, restartInhibit;
    integer err_count = 0;
    integer tests_run = 0;
    reg [5:0] s;
    always #5 clk = ~clk;
    amh_panel_model pnl (.clk(clk), .startKey(startKey), .ackInputFunction(ackInputFunction),
        .passwordBypassInput(passwordBypassInput), .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData));
    amh_anomaly_manager #(.N(8), .SEC_CYCLES(10), .WINDOW_CYCLES(50), .FLASH_CYCLES(4)) dut (
        .clk(clk), .nrst(nrst), .causeWarn(causeWarn), .causeUnload(causeUnload),
        .causeDeact(causeDeact), .causeAlarm(causeAlarm), .resetAnomalies(resetAnomalies),
        .parallelMode(parallelMode), .powerLow(powerLow), .optionBits(optionBits),
        .hornDuration(hornDuration), .password(PW), .startKey(startKey),
        .ackInputFunction(ackInputFunction), .passwordBypassInput(passwordBypassInput),
        .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData), .internalHorn(internalHorn),
        .externalHornOutput(externalHornOutput), .warnLamp(warnLamp), .alarmLamp(alarmLamp),
        .codeVisible(codeVisible), .activeClasses(activeClasses), .rampDown(rampDown),
        .generatorBreakerOpen(generatorBreakerOpen), .engineStopCool(engineStopCool),
        .engineStopNow(engineStopNow), .restartInhibit(restartInhibit));
    task chk(input string nm, input [15:0] seen, input [15:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task cy(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Lamps flash, so both levels are gathered over ten cycles, just over one flash period
    task blink(output [5:0] hl);
        reg [2:0] hi;
        reg [2:0] lo;
        hi = 3'h0;
        lo = 3'h0;
        repeat (10) begin
            cy(1);
            hi = hi | {warnLamp, alarmLamp, codeVisible};
            lo = lo | ~{warnLamp, alarmLamp, codeVisible};
        end
        hl = {hi, lo};
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        {causeWarn, causeUnload, causeDeact, causeAlarm} <= 32'h0;
        {resetAnomalies, parallelMode, powerLow} <= 3'h0;
        optionBits <= 16'h0000;
        hornDuration <= 10'h3E7;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        cy(2);
        chk("idle outputs", {internalHorn, activeClasses, restartInhibit}, 16'h0000);
        @(posedge clk) causeAlarm <= 8'h01;
        cy(2);
        chk("alarm class", activeClasses, 16'h0008);
        chk("alarm", {generatorBreakerOpen, engineStopCool, engineStopNow}, 16'h0005);
        chk("alarm inhibit", restartInhibit, 16'h0001);
        chk("horn pair", {internalHorn, externalHornOutput}, 16'h0003);
        blink(s);
        chk("alarm flash", s, 16'h001F);
        pnl.press_start;
        cy(2);
        chk("start silence", internalHorn, 16'h0000);
        blink(s);
        chk("silenced flash", {restartInhibit, s}, 16'h005F);
        pnl.ack_level(1'b1);
        cy(3);
        chk("ack input", restartInhibit, 16'h0000);
        blink(s);
        chk("acked steady", s, 16'h001C);
        @(posedge clk) begin
            causeAlarm <= 8'h03;
            causeDeact <= 8'h01;
            causeWarn <= 8'h01;
        end
        cy(3);
        chk("admission refused", {activeClasses, internalHorn}, 16'h0010);
        @(posedge clk) optionBits <= 16'h0001;
        cy(3);
        chk("bypass admits", activeClasses, 16'h000D);
        chk("held ack no silence", internalHorn, 16'h0001);
        pnl.ser(16'h0065, 16'h1111);
        pnl.ser(16'h0066, 16'h0033);
        cy(3);
        chk("wrong password", internalHorn, 16'h0001);
        pnl.ser(16'h0065, PW);
        pnl.ser(16'h0066, 16'h0033);
        cy(3);
        chk("serial silence", {internalHorn, restartInhibit}, 16'h0001);
        pnl.ser(16'h0065, PW);
        cy(60);
        pnl.ser(16'h0066, 16'h0034);
        cy(3);
        chk("late code", restartInhibit, 16'h0001);
        pnl.bypass(1'b1);
        pnl.ser(16'h0066, 16'h0034);
        cy(3);
        chk("bypass input ack", restartInhibit, 16'h0000);
        pnl.bypass(1'b0);
        @(posedge clk) {causeWarn, causeDeact, causeAlarm} <= 24'h0;
        cy(3);
        chk("acked warning gone", activeClasses, 16'h000C);
        @(posedge clk) resetAnomalies <= 1'b1;
        @(posedge clk) resetAnomalies <= 1'b0;
        cy(2);
        chk("reset clears", {activeClasses, engineStopNow}, 16'h0000);
        pnl.ack_level(1'b0);
        @(posedge clk) begin
            optionBits <= 16'h0000;
            hornDuration <= 10'h003;
            causeWarn <= 8'h02;
        end
        cy(2);
        chk("warn only", {activeClasses, engineStopCool, engineStopNow}, 16'h0004);
        chk("warn breaker", generatorBreakerOpen, 16'h0000);
        cy(20);
        chk("horn within duration", internalHorn, 16'h0001);
        cy(13);
        chk("horn expired", internalHorn, 16'h0000);
        blink(s);
        chk("warn flash", s, 16'h002F);
        @(posedge clk) causeWarn <= 8'h00;
        cy(3);
        chk("unacked warning kept", activeClasses, 16'h0001);
        pnl.ack_pulse;
        cy(3);
        chk("warning cleared", activeClasses, 16'h0000);
        @(posedge clk) begin
            parallelMode <= 1'b1;
            causeUnload <= 8'h01;
        end
        cy(2);
        chk("unload ramp", {rampDown, generatorBreakerOpen, engineStopCool}, 16'h0004);
        @(posedge clk) powerLow <= 1'b1;
        cy(2);
        chk("unload open", {rampDown, generatorBreakerOpen, engineStopCool}, 16'h0003);
        @(posedge clk) causeDeact <= 8'h01;
        cy(2);
        chk("deact with unload", activeClasses, 16'h0006);
        chk("deact", {generatorBreakerOpen, engineStopCool, engineStopNow}, 16'h0006);
        pnl.press_start;
        @(posedge clk) begin
            causeUnload <= 8'h03;
            causeWarn <= 8'h01;
        end
        cy(3);
        chk("unload refused", {activeClasses, internalHorn}, 16'h000C);
        @(posedge clk) hornDuration <= 10'h000;
        cy(5);
        @(posedge clk) causeAlarm <= 8'h01;
        cy(3);
        chk("alarm beside others", activeClasses, 16'h000E);
        chk("zero duration", internalHorn, 16'h0000);
        @(posedge clk) begin
            nrst <= 1'b0;
            {causeWarn, causeUnload, causeDeact, causeAlarm} <= 32'h0;
        end
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        cy(2);
        chk("second reset", {activeClasses, restartInhibit, engineStopNow}, 16'h0000);
        close_out;
    end
    // Tests need a few hundred cycles; a hang ends here as a failure
    initial begin
        #20000;
        err_count = err_count + 1;
        close_out;
    end
endmodule
